/* shared/strap_consts.svh */
// Offsets, bit positions, reset values and timing counts of the strap block
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH
`define LBR_IDX 8'h18
`define STS10_IDX 8'h1B
`define CTRL_IDX 8'h1C
`define LBR_ALIGN_BIT 12
`define LBR_SCR_BIT 13
`define LBR_CODE_BIT 14
`define STS10_SER_BIT 9
`define CTRL_SPEED_BIT 0
`define CTRL_RESET 32'h0000_0001
`define STRAP_SETTLE 3'h3
`endif

/* shared/strap_pkg.sv */
// Types shared by the strap and mode select block
package strap_pkg;
    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] d;
    } mii_tx_t;
    typedef struct packed {
        logic en;
        logic [4:0] d;
    } core_tx_t;
    typedef struct packed {
        logic dv;
        logic er;
        logic crs;
        logic col;
        logic [3:0] d;
    } mii_rx_t;
    typedef struct packed {
        logic serial;
        logic align;
        logic code;
        logic scr;
    } mode_t;
    typedef enum logic [0:0] {ST_WAIT, ST_HELD} cap_state_t;
endpackage

/* logic/phy_strap_mode_select.sv */
// Strap capture, mode registers and MII datapath selection
`include "strap_consts.svh"
module phy_strap_mode_select (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Strap pins, asynchronous
    input wire strap_pkg::mode_t STRAP,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // MII transmit from MAC, and toward the coding core
    input wire strap_pkg::mii_tx_t TX_IN,
    output strap_pkg::core_tx_t CORE_TX,
    // Receive from the coding core, and toward the MAC
    input wire strap_pkg::mii_rx_t CORE_RX,
    output strap_pkg::mii_rx_t RX_OUT,
    // Effective stage controls and capture status
    output strap_pkg::mode_t PATH,
    output logic CFG_VALID
);

    // Byte address of a register index
    function automatic logic [7:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'h0};
    endfunction

    strap_pkg::mode_t sync1_r;
    strap_pkg::mode_t sync2_r;
    strap_pkg::mode_t lat_r;
    strap_pkg::mode_t path_nxt;
    strap_pkg::cap_state_t state_r;
    strap_pkg::core_tx_t tx_nxt;
    strap_pkg::mii_rx_t rx_nxt;
    logic [2:0] cnt_r;
    logic cap_en;
    logic speed100_r;
    logic wr_go;
    logic [31:0] rd_nxt;
    logic run_r;
    localparam logic [31:0] ctrl_reset_w = `CTRL_RESET;

    // Two-stage synchroniser on the strap pins
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= STRAP;
            sync2_r <= sync1_r;
        end
    end

    // Capture once the synchroniser has flushed after reset
    assign cap_en = (state_r == strap_pkg::ST_WAIT) && (cnt_r == `STRAP_SETTLE);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= strap_pkg::ST_WAIT;
            cnt_r <= 3'h0;
        end else begin
            case (state_r)
                strap_pkg::ST_WAIT: begin
                    cnt_r <= cnt_r + 3'h1;
                    if (cap_en) begin
                        state_r <= strap_pkg::ST_HELD;
                    end
                end
                default: begin
                    cnt_r <= cnt_r;
                end
            endcase
        end
    end

    // Avalon handshake: one wait cycle, then the access completes
    assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            AVS_WAITREQUEST <= 1'b1;
        end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

    // Latched strap bits; software may later override bypass bits
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            lat_r <= '0;
        end else if (cap_en) begin
            lat_r <= sync2_r;
        end else if (wr_go && AVS_ADDRESS == byte_addr(`LBR_IDX) && AVS_BYTEENABLE[1]) begin
            lat_r.align <= AVS_WRITEDATA[`LBR_ALIGN_BIT];
            lat_r.scr <= AVS_WRITEDATA[`LBR_SCR_BIT];
            lat_r.code <= AVS_WRITEDATA[`LBR_CODE_BIT];
        end
    end

    // Speed select; the rate detection sits outside this block
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            speed100_r <= ctrl_reset_w[`CTRL_SPEED_BIT];
        end else if (wr_go && AVS_ADDRESS == byte_addr(`CTRL_IDX) && AVS_BYTEENABLE[0]) begin
            speed100_r <= AVS_WRITEDATA[`CTRL_SPEED_BIT];
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (AVS_ADDRESS == byte_addr(`LBR_IDX)) begin
            rd_nxt[`LBR_ALIGN_BIT] = lat_r.align;
            rd_nxt[`LBR_SCR_BIT] = lat_r.scr;
            rd_nxt[`LBR_CODE_BIT] = lat_r.code;
        end else if (AVS_ADDRESS == byte_addr(`STS10_IDX)) begin
            rd_nxt[`STS10_SER_BIT] = lat_r.serial;
        end else if (AVS_ADDRESS == byte_addr(`CTRL_IDX)) begin
            rd_nxt[`CTRL_SPEED_BIT] = speed100_r;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && AVS_WAITREQUEST) begin
            AVS_READDATA <= rd_nxt;
        end
    end

    // Effective modes from latched bits and the speed select only; pins never steer directly
    always_comb begin
        path_nxt.serial = lat_r.serial && !speed100_r;
        path_nxt.align = lat_r.align && speed100_r;
        path_nxt.code = (lat_r.code || lat_r.align) && speed100_r;
        path_nxt.scr = (lat_r.scr || lat_r.align) && speed100_r;
    end

    // Transmit selection; TX_ER gating differs between bypass modes
    always_comb begin
        tx_nxt.en = TX_IN.en;
        if (path_nxt.serial) begin
            tx_nxt.d = {4'h0, TX_IN.d[0]};
        end else if (path_nxt.align) begin
            tx_nxt.d = {TX_IN.er, TX_IN.d};
        end else begin
            tx_nxt.d = {TX_IN.er && TX_IN.en, TX_IN.d};
        end
    end

    // Receive selection; control lines forced quiet under alignment bypass
    always_comb begin
        rx_nxt = CORE_RX;
        if (path_nxt.serial) begin
            rx_nxt.d = {3'h0, CORE_RX.d[0]};
        end else if (path_nxt.align) begin
            rx_nxt.dv = 1'b0;
            rx_nxt.er = 1'b0;
            rx_nxt.crs = 1'b0;
            rx_nxt.col = 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            CORE_TX <= '0;
            RX_OUT <= '0;
            PATH <= '0;
            CFG_VALID <= 1'b0;
        end else begin
            CORE_TX <= tx_nxt;
            RX_OUT <= rx_nxt;
            PATH <= path_nxt;
            CFG_VALID <= (state_r == strap_pkg::ST_HELD) || cap_en;
        end
    end

    // Checks start one edge after release; outputs still hold reset values before that
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            run_r <= 1'b0;
        end else begin
            run_r <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN || !run_r);

    property p_serial_tx;
        path_nxt.serial |=> CORE_TX.d == {4'h0, $past(TX_IN.d[0])};
    endproperty
    a_serial_tx: assert property (p_serial_tx) else $error("serial tx not on bit 0");

    property p_ser_ignored;
        speed100_r |=> !PATH.serial;
    endproperty
    a_ser_ignored: assert property (p_ser_ignored) else $error("serial at 100");

    property p_nibble_tx;
        !path_nxt.serial && TX_IN.en |=> CORE_TX.d[3:0] == $past(TX_IN.d);
    endproperty
    a_nibble_tx: assert property (p_nibble_tx) else $error("nibble tx lost");

    property p_capture;
        cap_en ##1 !wr_go |=> lat_r == $past(sync2_r, 2);
    endproperty
    a_capture: assert property (p_capture) else $error("strap lost");

    property p_align_path;
        lat_r.align && speed100_r |=> PATH.align && PATH.code && PATH.scr;
    endproperty
    a_align_path: assert property (p_align_path) else $error("stages not bypassed");

    property p_align_ctrl;
        path_nxt.align |=> !RX_OUT.crs && !RX_OUT.dv && !RX_OUT.er && !RX_OUT.col;
    endproperty
    a_align_ctrl: assert property (p_align_ctrl) else $error("ctrl active in align");

    property p_align_er;
        path_nxt.align && !TX_IN.en |=> CORE_TX.d[4] == $past(TX_IN.er);
    endproperty
    a_align_er: assert property (p_align_er) else $error("tx_er gated in align");

    property p_code_path;
        lat_r.code && speed100_r |=> PATH.code;
    endproperty
    a_code_path: assert property (p_code_path) else $error("code not bypassed");

    property p_pcs_normal;
        !path_nxt.align |=> RX_OUT.crs == $past(CORE_RX.crs) && RX_OUT.col == $past(CORE_RX.col);
    endproperty
    a_pcs_normal: assert property (p_pcs_normal) else $error("pcs signal altered");

    property p_code_er;
        path_nxt.code && !path_nxt.align && !TX_IN.en |=> !CORE_TX.d[4];
    endproperty
    a_code_er: assert property (p_code_er) else $error("tx_er not gated");

    property p_scr_path;
        lat_r.scr && speed100_r |=> PATH.scr;
    endproperty
    a_scr_path: assert property (p_scr_path) else $error("scrambler not bypassed");

    property p_pin_ignored;
        state_r == strap_pkg::ST_HELD && !wr_go |=> $stable(lat_r);
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("live pin changed mode");

    // Receive lanes and the transmit error lane
    property p_serial_rx;
        path_nxt.serial |=> RX_OUT.d == {3'h0, $past(CORE_RX.d[0])};
    endproperty
    a_serial_rx: assert property (p_serial_rx) else $error("serial rx not on bit 0");

    property p_nibble_rx;
        !path_nxt.serial |=> RX_OUT.d == $past(CORE_RX.d);
    endproperty
    a_nibble_rx: assert property (p_nibble_rx) else $error("nibble rx lost");

    property p_pcs_flags;
        !path_nxt.align |=> RX_OUT.dv == $past(CORE_RX.dv) && RX_OUT.er == $past(CORE_RX.er);
    endproperty
    a_pcs_flags: assert property (p_pcs_flags) else $error("pcs flag altered");

    property p_code_er_live;
        path_nxt.code && !path_nxt.align && TX_IN.en |=> CORE_TX.d[4] == $past(TX_IN.er);
    endproperty
    a_code_er_live: assert property (p_code_er_live) else $error("tx_er lost");

    // Bus answer and capture status; a stuck waitrequest would hang any master
    property p_wait_one;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

    property p_cfg_held;
        state_r == strap_pkg::ST_HELD |=> CFG_VALID;
    endproperty
    a_cfg_held: assert property (p_cfg_held) else $error("cfg_valid dropped");

endmodule // phy_strap_mode_select

/* dv/mac_model.sv */
// MAC-side model driving MII transmit toward the block
module mac_model (
    // Clock
    input wire logic clk,
    // Wanted transmit sample and current transfer mode
    input wire strap_pkg::mii_tx_t tx_req,
    input wire logic serial,
    // MII transmit toward the block
    output strap_pkg::mii_tx_t tx_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] junk_r = 3'h0;

    // Lines unused in serial mode keep toggling, so any leak shows
    always @(posedge clk) begin
        junk_r <= junk_r + 3'h5;
    end

    // Serial transfer carries data on bit 0 only
    assign tx_out = serial ? {tx_req.en, tx_req.er, junk_r, tx_req.d[0]} : tx_req;
endmodule // mac_model

/* dv/tb_top.sv */
// Self-checking bench for strap capture, mode registers and MII path
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    strap_pkg::mode_t strap = '0;
    logic [7:0] addr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic wait_req;
    strap_pkg::mii_tx_t tx_req = '0;
    strap_pkg::mii_tx_t tx_in;
    strap_pkg::core_tx_t core_tx;
    strap_pkg::mii_rx_t core_rx = '0;
    strap_pkg::mii_rx_t rx_out;
    strap_pkg::mode_t path;
    logic cfg_valid;
    logic ser10 = 1'b0;
    logic [31:0] rv;
    int fail_count = 0;
    int tests_run = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    phy_strap_mode_select phy_strap_mode_select_inst (.CLK(clk), .RESETN(resetn), .STRAP(strap),
        .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .TX_IN(tx_in),
        .CORE_TX(core_tx), .CORE_RX(core_rx), .RX_OUT(rx_out), .PATH(path), .CFG_VALID(cfg_valid));
    mac_model mac_model_inst (.clk(clk), .tx_req(tx_req), .serial(ser10), .tx_out(tx_in));

    // Compare and count
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One Avalon-MM access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        rd_en <= !wr;
        wr_en <= wr;
        wdata <= wd;
        be <= b;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0);
        rv = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        check("wait cycles", 32'(n), 32'h2);
    endtask

    // Reset with the given straps; they stay stable well past capture
    task boot(input strap_pkg::mode_t m);
        int n;
        n = 0;
        @(posedge clk);
        resetn <= 1'b0;
        strap <= m;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        while (cfg_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check("cfg_valid", 32'(cfg_valid), 32'h1);
        repeat (2) @(posedge clk);
    endtask

    // Capture into registers; pins flipped afterwards must not matter
    task t_regs(input strap_pkg::mode_t m);
        boot(m);
        strap <= ~m;
        bus(1'b0, 8'h60, 32'h0, 4'hF);
        check("reg18", rv, {17'h0, m.code, m.scr, m.align, 12'h0});
        bus(1'b0, 8'h6C, 32'h0, 4'hF);
        check("reg1b", rv, {22'h0, m.serial, 9'h0});
        check("path100", 32'(path),
            32'({1'b0, m.align, m.code | m.align, m.scr | m.align}));
    endtask

    // Lane gating, read-only and unmapped places, software bypass
    task t_access;
        bus(1'b0, 8'h70, 32'h0, 4'hF);
        check("ctrl", rv, 32'h1);
        bus(1'b1, 8'h60, 32'h7000, 4'h1);
        bus(1'b0, 8'h60, 32'h0, 4'hF);
        check("reg18 lane", rv, 32'h0);
        bus(1'b1, 8'h60, 32'h5000, 4'h2);
        bus(1'b0, 8'h60, 32'h0, 4'hF);
        check("reg18 rw", rv, 32'h5000);
        check("path sw", 32'(path), 32'h7);
        bus(1'b1, 8'h6C, 32'h200, 4'hF);
        bus(1'b0, 8'h6C, 32'h0, 4'hF);
        check("reg1b ro", rv, 32'h0);
        bus(1'b0, 8'h04, 32'h0, 4'hF);
        check("unmapped", rv, 32'h0);
    endtask

    // Four transmit and receive samples under the given path
    task t_path(input logic sm, input logic al);
        strap_pkg::core_tx_t et;
        strap_pkg::mii_rx_t er;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            tx_req <= {i[0], i[1] & !sm, 4'(i * 5 + 6)};
            core_rx <= {i[1], i[0], !i[0], i[1], 4'(9 - i)};
            @(posedge clk);
            #1;
            et = {tx_req.en, al ? tx_req.er : tx_req.er & tx_req.en,
                sm ? {3'h0, tx_req.d[0]} : tx_req.d};
            er = al ? {4'h0, core_rx.d} : sm ? {core_rx[7:4], 3'h0, core_rx.d[0]} : core_rx;
            check("core_tx", 32'(core_tx), 32'(et));
            check("rx_out", 32'(rx_out), 32'(er));
        end
    endtask

    // Main sequence
    initial begin
        t_regs(4'hA);
        t_path(1'b0, 1'b0);
        t_regs(4'h5);
        t_path(1'b0, 1'b1);
        t_regs(4'h0);
        t_access;
        t_regs(4'hB);
        bus(1'b1, 8'h70, 32'h0, 4'h1);
        ser10 <= 1'b1;
        repeat (2) @(posedge clk);
        check("path10", 32'(path), 32'h8);
        t_path(1'b1, 1'b0);
        close_out;
    end

    // Watchdog well beyond the expected run of about 130 cycles
    initial begin
        #200000;
        fail_count++;
        close_out;
    end
endmodule // tb_top
